// ### fifo_pkg.sv
// Shared constants for the dual-clock 9-bit buffer
package fifo_pkg;
    localparam int unsigned DATA_W          = 9;
    localparam int unsigned DEPTH_DEFAULT   = 64;
    localparam int unsigned OFFSET_W        = 8;
    localparam int unsigned SYNC_STAGES     = 2;
    // Offset register sequence indices
    localparam logic [1:0]  SEL_EMPTY_LOW   = 2'h0;
    localparam logic [1:0]  SEL_EMPTY_HIGH  = 2'h1;
    localparam logic [1:0]  SEL_FULL_LOW    = 2'h2;
    localparam logic [1:0]  SEL_FULL_HIGH   = 2'h3;
    // Reset values of the offset registers
    localparam logic [7:0]  EMPTY_LOW_RST   = 8'h07;
    localparam logic [7:0]  EMPTY_HIGH_RST  = 8'h00;
    localparam logic [7:0]  FULL_LOW_RST    = 8'h07;
    localparam logic [7:0]  FULL_HIGH_RST   = 8'h00;
    // Pin function chosen at reset
    typedef enum logic {MODE_PROG_FLAGS, MODE_TWO_ENABLES} pin_mode_e;
endpackage : fifo_pkg

// ### gray_sync.sv
// Two-stage synchroniser for a gray-coded pointer
`timescale 1ns/1ps
module gray_sync #(
    parameter int unsigned W = 7
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule : gray_sync

// ### dual_clock_fifo_9bit.sv
// Dual-clock 9-bit buffer with programmable almost flags and offset registers
// Function
// - Reset puts write and read pointers at the first location.
// - Reset drives full and almost-full high, empty and almost-empty low.
// - Reset clears the output register and loads offset defaults.
// - Offset mode: primary enable low writes each write edge, else input holds.
// - Full ignores write enables, flag low; releases after a read.
// - Full and almost-full change only on write clock edges.
// - Empty and almost-empty change only on read clock edges.
// - Both read enables low moves next word into output register.
// - Either read enable high keeps output and consumes nothing.
// - Empty ignores read enables, flag low; raised after a write.
// - Output enable low drives output register, high floats the bus.
// - Pin high at reset makes it an active-high second write enable.
// - Two-enable mode writes only when primary low and second high.
// - Pin low at reset selects offset mode with four registers: two 8-bit low, two narrower high.
// - Load writes go empty low, empty high, full low, full high, wrap.
// - Sequence pointer persists when load rises; next load continues.
// - Load with read enables low reads offsets in the same order.
// - Full offset defaults to seven in the low register.
// - Empty offset defaults to seven.
// - Empty flag low when read pointer equals write pointer.
// - Almost-full low once count reaches depth minus full offset.
// - Almost-empty low while count is at most the empty offset.
`timescale 1ns/1ps
module dual_clock_fifo_9bit
    import fifo_pkg::*;
#(
    parameter int unsigned DEPTH = fifo_pkg::DEPTH_DEFAULT
) (
    input  wire logic                        core_clk,
    input  wire logic                        read_clk,
    input  wire logic                        reset_n,
    input  wire logic [fifo_pkg::DATA_W-1:0] write_data_in,
    input  wire logic                        write_enable_primary_n,
    input  wire logic                        second_enable_or_load_pin,
    input  wire logic                        read_enable_a_n,
    input  wire logic                        read_enable_b_n,
    input  wire logic                        output_enable_n,
    output logic      [fifo_pkg::DATA_W-1:0] read_data_out,
    output logic      [fifo_pkg::DATA_W-1:0] read_data_oe,
    output logic                             full_flag_n,
    output logic                             almost_full_flag_n,
    output logic                             empty_flag_n,
    output logic                             almost_empty_flag_n
);
    import fifo_pkg::*;

    localparam int unsigned AW   = $clog2(DEPTH);
    localparam int unsigned PW   = AW + 1;
    localparam int unsigned HI_W = (AW > OFFSET_W) ? AW - OFFSET_W : 1;

    // Depth must be a power of two whose word count fits the 16-bit offsets
    if (DEPTH < 16 || (DEPTH & (DEPTH - 1)) != 0 || AW > 2 * OFFSET_W - 1) begin : g_depth_bad
        $error("DEPTH must be a power of two from 16 to 32768");
    end

    // Core clock is the write clock; reset is synchronised into the read domain
    // Only the second flop is read, so the read side leaves reset cleanly
    logic [1:0] rrst_sync_reg;
    logic       rrst_n;
    always_ff @(posedge read_clk) begin
        rrst_sync_reg <= {rrst_sync_reg[0], reset_n};
    end
    assign rrst_n = rrst_sync_reg[1];

    // ---------------- Write domain ----------------
    logic [DATA_W-1:0] mem_reg [DEPTH];
    logic [PW-1:0]     wptr_reg;
    logic [PW-1:0]     wgray_reg;
    logic [PW-1:0]     rgray_sync;
    logic              full_reg;
    logic              afull_reg;
    pin_mode_e         mode_reg;
    logic [1:0]        wsel_reg;
    logic [7:0]        empty_low_reg;
    logic [HI_W-1:0]   empty_high_reg;
    logic [7:0]        full_low_reg;
    logic [HI_W-1:0]   full_high_reg;

    // Gray to binary conversion of a synchronised read or write pointer
    function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        b = '0;
        for (int i = PW - 1; i >= 0; i--) begin
            b[i] = g[i] ^ ((i == PW - 1) ? 1'b0 : b[i+1]);
        end
        return b;
    endfunction : gray2bin

    // Write decode: both modes need primary low and pin high, load redirects to offsets
    wire           load_mode   = (mode_reg == MODE_PROG_FLAGS) && !second_enable_or_load_pin;
    wire           wr_req      = (mode_reg == MODE_TWO_ENABLES)
                                 ? (!write_enable_primary_n && second_enable_or_load_pin)
                                 : (!write_enable_primary_n && second_enable_or_load_pin);
    wire           wr_do       = wr_req && !full_reg;
    wire           off_wr      = load_mode && !write_enable_primary_n;
    wire [PW-1:0]  wptr_next   = wptr_reg + PW'(wr_do);
    wire [PW-1:0]  rptr_w      = gray2bin(rgray_sync);
    wire [PW-1:0]  wcount_next = wptr_next - rptr_w;
    wire [15:0]    full_off    = 16'({full_high_reg, full_low_reg});
    wire [PW:0]    afull_lim   = (PW+1)'(DEPTH) - (PW+1)'(full_off);
    wire           full_next   = wcount_next == PW'(DEPTH);
    wire           afull_next  = {1'b0, wcount_next} >= afull_lim;

    // Pin function latched only while reset is held
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            mode_reg <= second_enable_or_load_pin ? MODE_TWO_ENABLES : MODE_PROG_FLAGS;
        end
    end

    // Array write and write pointer
    always_ff @(posedge core_clk) begin
        if (wr_do) begin
            mem_reg[wptr_reg[AW-1:0]] <= write_data_in;
        end
    end
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            wptr_reg  <= '0;
            wgray_reg <= '0;
            full_reg  <= 1'b0;
            afull_reg <= 1'b0;
            // Pins come straight from flops, inactive high in reset
            full_flag_n        <= 1'b1;
            almost_full_flag_n <= 1'b1;
        end else begin
            wptr_reg  <= wptr_next;
            wgray_reg <= wptr_next ^ (wptr_next >> 1);
            full_reg  <= full_next;
            afull_reg <= afull_next;
            full_flag_n        <= !full_next;
            almost_full_flag_n <= !afull_next;
        end
    end

    // Offset registers written in a wrapping four-step order
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            wsel_reg       <= SEL_EMPTY_LOW;
            empty_low_reg  <= EMPTY_LOW_RST;
            empty_high_reg <= HI_W'(EMPTY_HIGH_RST);
            full_low_reg   <= FULL_LOW_RST;
            full_high_reg  <= HI_W'(FULL_HIGH_RST);
        end else if (off_wr) begin
            wsel_reg <= wsel_reg + 2'h1;
            unique case (wsel_reg)
                SEL_EMPTY_LOW:  empty_low_reg  <= write_data_in[7:0];
                SEL_EMPTY_HIGH: empty_high_reg <= write_data_in[HI_W-1:0];
                SEL_FULL_LOW:   full_low_reg   <= write_data_in[7:0];
                SEL_FULL_HIGH:  full_high_reg  <= write_data_in[HI_W-1:0];
            endcase
        end
    end

    // ---------------- Read domain ----------------
    logic [PW-1:0]     rptr_reg;
    logic [PW-1:0]     rgray_reg;
    logic [PW-1:0]     wgray_sync;
    logic              empty_reg;
    logic              aempty_reg;
    logic [DATA_W-1:0] dout_reg;
    logic [1:0]        rsel_reg;
    logic [1:0]        oe_sync_reg;
    logic [1:0]        ld_sync_reg;

    // Load pin reaches the read side through two flops; idle level is high
    // The mode flop is quasi-static: it only moves while reset_n is low, so it settles before the read side leaves reset
    always_ff @(posedge read_clk) begin
        if (!rrst_n) begin
            ld_sync_reg <= 2'h3;
        end else begin
            ld_sync_reg <= {ld_sync_reg[0], second_enable_or_load_pin};
        end
    end
    wire           rd_load_mode = (mode_reg == MODE_PROG_FLAGS) && !ld_sync_reg[1];

    // Offsets are quasi-static; read side uses the empty offset for almost-empty, all four in load mode
    wire           rd_en      = !read_enable_a_n && !read_enable_b_n;
    wire           rd_load    = rd_load_mode && rd_en;
    wire           rd_do      = rd_en && !rd_load_mode && !empty_reg;
    wire [PW-1:0]  rptr_next  = rptr_reg + PW'(rd_do);
    wire [PW-1:0]  wptr_r     = gray2bin(wgray_sync);
    wire [PW-1:0]  rcount     = wptr_r - rptr_next;
    wire [15:0]    empty_off  = 16'({empty_high_reg, empty_low_reg});
    wire           empty_next = wptr_r == rptr_next;
    wire           aempty_nxt = {{(16-PW){1'b0}}, rcount} <= empty_off;
    wire [DATA_W-1:0] off_rd_word =
        (rsel_reg == SEL_EMPTY_LOW)  ? DATA_W'(empty_low_reg)  :
        (rsel_reg == SEL_EMPTY_HIGH) ? DATA_W'(empty_high_reg) :
        (rsel_reg == SEL_FULL_LOW)   ? DATA_W'(full_low_reg)   :
                                       DATA_W'(full_high_reg);

    always_ff @(posedge read_clk) begin
        if (!rrst_n) begin
            rptr_reg   <= '0;
            rgray_reg  <= '0;
            empty_reg  <= 1'b1;
            aempty_reg <= 1'b1;
            dout_reg   <= '0;
            rsel_reg   <= SEL_EMPTY_LOW;
            // Pins come straight from flops, active low in reset
            empty_flag_n        <= 1'b0;
            almost_empty_flag_n <= 1'b0;
        end else begin
            rptr_reg   <= rptr_next;
            rgray_reg  <= rptr_next ^ (rptr_next >> 1);
            empty_reg  <= empty_next;
            aempty_reg <= aempty_nxt;
            empty_flag_n        <= !empty_next;
            almost_empty_flag_n <= !aempty_nxt;
            if (rd_do) begin
                dout_reg <= mem_reg[rptr_reg[AW-1:0]];
            end else if (rd_load) begin
                dout_reg <= off_rd_word;
                rsel_reg <= rsel_reg + 2'h1;
            end
        end
    end

    // Output enable is a pin: two flops before it drives the enables
    always_ff @(posedge read_clk) begin
        if (!rrst_n) begin
            oe_sync_reg  <= 2'b00;
            read_data_oe <= '0;
        end else begin
            oe_sync_reg  <= {oe_sync_reg[0], !output_enable_n};
            read_data_oe <= {DATA_W{oe_sync_reg[1]}};
        end
    end
    assign read_data_out       = dout_reg;

    // Pointer crossings
    gray_sync #(.W(PW)) u_rptr_to_w (
        .clk   (core_clk),
        .rst_n (reset_n),
        .d     (rgray_reg),
        .q     (rgray_sync)
    );
    gray_sync #(.W(PW)) u_wptr_to_r (
        .clk   (read_clk),
        .rst_n (rrst_n),
        .d     (wgray_reg),
        .q     (wgray_sync)
    );

    // Checks

    // Reset state of both sides
    reset_flags_a: assert property (@(posedge core_clk)
        !reset_n |=> full_flag_n && almost_full_flag_n)
        else $error("reset flags wrong");
    empty_reset_a: assert property (@(posedge read_clk)
        !rrst_n |=> !empty_flag_n && !almost_empty_flag_n)
        else $error("reset empty flags wrong");
    write_ptr_reset_a: assert property (@(posedge core_clk)
        !reset_n |=> wptr_reg == '0)
        else $error("write pointer not cleared");
    read_ptr_reset_a: assert property (@(posedge read_clk)
        !rrst_n |=> rptr_reg == '0 && dout_reg == '0)
        else $error("read side not cleared");
    offset_reset_a: assert property (@(posedge core_clk)
        !reset_n |=> full_low_reg == FULL_LOW_RST && empty_low_reg == EMPTY_LOW_RST)
        else $error("offset defaults wrong");

    // Write side gating
    write_advance_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_do |=> wptr_reg == $past(wptr_reg) + PW'(1))
        else $error("write pointer stuck");
    write_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        !wr_req |=> $stable(wptr_reg))
        else $error("write without enable");
    two_enable_gate_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (mode_reg == MODE_TWO_ENABLES && (write_enable_primary_n || !second_enable_or_load_pin))
        |=> $stable(wptr_reg))
        else $error("two-enable write gate open");
    full_blocks_write_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        full_reg |=> $stable(wptr_reg) || !$past(full_reg))
        else $error("write while full");

    // Write side flags follow the count
    full_flag_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        full_next |=> !full_flag_n)
        else $error("full flag missed");
    almost_full_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        afull_next |=> !almost_full_flag_n)
        else $error("almost-full flag missed");
    almost_full_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        !afull_next |=> almost_full_flag_n)
        else $error("almost-full flag stuck");

    // Read side transfer and hold
    empty_blocks_read_a: assert property (@(posedge read_clk) disable iff (!rrst_n)
        empty_reg |=> $stable(rptr_reg))
        else $error("read taken while empty");
    hold_output_a: assert property (@(posedge read_clk) disable iff (!rrst_n)
        (read_enable_a_n || read_enable_b_n) |=> $stable(dout_reg) && $stable(rptr_reg))
        else $error("output changed without read");
    read_advance_a: assert property (@(posedge read_clk) disable iff (!rrst_n)
        rd_do |=> rptr_reg == $past(rptr_reg) + PW'(1))
        else $error("read pointer stuck");

    // Read side flags follow the count
    empty_match_a: assert property (@(posedge read_clk) disable iff (!rrst_n)
        empty_reg == ($past(wptr_r) == rptr_reg) || $past(!rrst_n))
        else $error("empty mismatch");
    almost_empty_a: assert property (@(posedge read_clk) disable iff (!rrst_n)
        aempty_nxt |=> !almost_empty_flag_n)
        else $error("almost-empty flag missed");

    // Output drive follows the synchronised enable
    drive_follow_a: assert property (@(posedge read_clk) disable iff (!rrst_n)
        read_data_oe == {DATA_W{$past(oe_sync_reg[1])}})
        else $error("drive enable wrong");

    // Pin function and offset sequencing
    mode_fixed_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        $past(reset_n) |-> $stable(mode_reg))
        else $error("mode changed");
    offset_seq_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        off_wr |=> wsel_reg == $past(wsel_reg) + 2'h1)
        else $error("offset order wrong");
    seq_persist_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        !off_wr |=> $stable(wsel_reg))
        else $error("sequence lost");
    offset_read_a: assert property (@(posedge read_clk) disable iff (!rrst_n)
        rd_load |=> dout_reg == $past(off_rd_word) && $stable(rptr_reg))
        else $error("offset readback wrong");
endmodule : dual_clock_fifo_9bit

// ### fifo_reader_model.sv
// Reader logic that drains the buffer on the read clock
`timescale 1ns/1ps
module fifo_reader_model (
    input  wire logic       read_clk,
    input  wire logic       empty_flag_n,
    input  wire logic [8:0] read_data_out,
    input  wire logic       stall,
    input  wire logic       force_rd,
    input  wire logic [7:0] want,
    output logic            read_enable_a_n,
    output logic            read_enable_b_n
);
    logic [8:0] got [$];
    logic [7:0] taken = 8'h00;
    logic       pend  = 1'b0;
    int         cyc   = 0;

    // Count a read where enables are low and the flag allows it; keep its word next edge
    always @(posedge read_clk) begin
        if (pend)
            got.push_back(read_data_out);
        pend = !read_enable_a_n && !read_enable_b_n && (empty_flag_n || force_rd);
        if (pend)
            taken = taken + 8'h01;
        cyc++;
        #1;
        read_enable_a_n <= !(taken < want);
        read_enable_b_n <= stall && cyc[0]; // Stalls every other edge
    end

    initial begin
        read_enable_a_n = 1'b1;
        read_enable_b_n = 1'b1;
    end
endmodule : fifo_reader_model

// ### test_dual_clock_fifo_9bit.sv
// Self-checking bench for the dual-clock 9-bit buffer
`timescale 1ns/1ps
module test_dual_clock_fifo_9bit;
    import fifo_pkg::*;
    logic       core_clk, read_clk, reset_n, wen_n, pin, oe_n, stall, force_rd;
    logic [8:0] din, dout, doe;
    logic       full_n, afull_n, empty_n, aempty_n, ren_a_n, ren_b_n;
    logic [7:0] want;
    int         mismatches = 0;
    int         checks     = 0;
    int         cycles     = 0;
    int         gi         = 0;
    logic [8:0] dflt [4] = '{9'h007, 9'h000, 9'h007, 9'h000};
    logic [8:0] prog [4] = '{9'h003, 9'h000, 9'h002, 9'h000};

    dual_clock_fifo_9bit #(.DEPTH(16)) dut (
        .core_clk(core_clk), .read_clk(read_clk), .reset_n(reset_n),
        .write_data_in(din), .write_enable_primary_n(wen_n),
        .second_enable_or_load_pin(pin), .read_enable_a_n(ren_a_n),
        .read_enable_b_n(ren_b_n), .output_enable_n(oe_n), .read_data_out(dout),
        .read_data_oe(doe), .full_flag_n(full_n), .almost_full_flag_n(afull_n),
        .empty_flag_n(empty_n), .almost_empty_flag_n(aempty_n));

    fifo_reader_model rdr (
        .read_clk(read_clk), .empty_flag_n(empty_n), .read_data_out(dout),
        .stall(stall), .force_rd(force_rd), .want(want),
        .read_enable_a_n(ren_a_n), .read_enable_b_n(ren_b_n));

    // Write clock and an unrelated read clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        read_clk = 1'b0;
        #3;
        forever #7.5 read_clk = ~read_clk;
    end

    // Hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            end_sim();
        end
    end

    task automatic cmp(string what, logic [8:0] exp, logic [8:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    task automatic cmp_fl(string what, logic [3:0] exp);
        checks++;
        if ({full_n, afull_n, empty_n, aempty_n} !== exp) begin
            mismatches++;
            $display("BAD %s expected %b seen %b", what, exp,
                     {full_n, afull_n, empty_n, aempty_n});
        end
    endtask : cmp_fl

    task automatic do_reset(input logic p);
        @(posedge core_clk);
        #1;
        reset_n = 1'b0;
        pin = p;
        repeat (8) @(posedge core_clk);
        #1;
        cmp_fl("reset flags", 4'b1100);
        cmp("reset data", 9'h000, dout);
        reset_n = 1'b1;
        pin = 1'b1;
        repeat (4) @(posedge core_clk);
    endtask : do_reset

    task automatic wr(input int n, input logic [8:0] base, input logic p);
        @(posedge core_clk);
        #1;
        pin = p;
        wen_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            din = base + 9'(i);
            @(posedge core_clk);
            #1;
        end
        wen_n = 1'b1;
        pin = 1'b1;
        repeat (6) @(posedge core_clk);
    endtask : wr

    task automatic rd(input int n, input logic f);
        @(posedge read_clk);
        #1;
        force_rd = f;
        want = want + 8'(n);
        for (int i = 0; i < 300 && rdr.taken != want; i++) @(posedge read_clk);
        cmp("reads taken", 9'(want), 9'(rdr.taken));
        repeat (2) @(posedge read_clk);
        #1;
        force_rd = 1'b0;
        repeat (6) @(posedge core_clk);
    endtask : rd

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    // Offset load and readback, fill to full, drain to empty, then two-enable mode
    initial begin
        reset_n = 1'b0; wen_n = 1'b1; pin = 1'b0; oe_n = 1'b1; din = 9'h000;
        stall = 1'b1; force_rd = 1'b0; want = 8'h00;
        do_reset(1'b0);
        pin = 1'b0;
        rd(4, 1'b1);
        for (int i = 0; i < 4; i++) cmp("offset default", dflt[i], rdr.got[gi+i]);
        gi += 4;
        wr(1, 9'h009, 1'b0); // Offset writes and reads kept apart
        wr(1, 9'h0FE, 1'b0);
        wr(1, 9'h002, 1'b0);
        wr(1, 9'h100, 1'b0);
        wr(1, 9'h003, 1'b0);
        pin = 1'b0;
        rd(4, 1'b1);
        for (int i = 0; i < 4; i++) cmp("offset readback", prog[i], rdr.got[gi+i]);
        gi += 4;
        wr(13, 9'h020, 1'b1);
        cmp_fl("thirteen words", 4'b1111);
        wr(1, 9'h02D, 1'b1);
        cmp_fl("fourteen words", 4'b1011);
        wr(3, 9'h02E, 1'b1);
        cmp_fl("full", 4'b0011);
        cmp("drive off", 9'h000, doe);
        oe_n = 1'b0;
        repeat (4) @(posedge core_clk);
        cmp("drive on", 9'h1FF, doe);
        rd(12, 1'b0);
        cmp_fl("four words", 4'b1111);
        rd(1, 1'b0);
        cmp_fl("three words", 4'b1110);
        rd(3, 1'b0);
        cmp_fl("empty", 4'b1100);
        for (int i = 0; i < 16; i++) cmp("word", 9'h020 + 9'(i), rdr.got[gi+i]);
        gi += 16;
        rd(1, 1'b1);
        cmp("read when empty", 9'h02F, rdr.got[gi]);
        gi++;
        do_reset(1'b1);
        wr(2, 9'h055, 1'b0);
        cmp_fl("second enable low", 4'b1100);
        wr(1, 9'h1AA, 1'b1);
        cmp_fl("second enable high", 4'b1110);
        rd(1, 1'b0);
        cmp("two-enable word", 9'h1AA, rdr.got[gi]);
        end_sim();
    end
endmodule : test_dual_clock_fifo_9bit
